// file: uart_ctl.sv
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "uart_ctl_map.svh"
module uart_ctl
    import uart_ctl_pkg::*;
#(
    parameter int AW = 8,
    parameter int DW = 8,
    parameter int LW = `CTRL_THR_W
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [AW-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    output logic irq,
    input wire logic [DW-1:0] tx_data,
    output logic tx_par_bit,
    input rx_char_t rx_char,
    output logic rx_par_err,
    input rx_pop_t rx_pop,
    input wire logic rx_overrun,
    input wire logic [LW-1:0] tx_fifo_level,
    input wire logic tx_fifo_full,
    input wire logic tx_shift_busy,
    input wire logic ring_indicator_in,
    input wire logic carrier_detect_in,
    input wire logic data_set_ready_in,
    input wire logic clear_to_send_in,
    output parity_sel_t parity_mode,
    output logic smart_card_en
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    parity_sel_t par_reg;
    logic smart_reg;
    tx_irq_mode_t txmode_reg;
    logic [LW-1:0] thr_reg;
    logic [3:0] err_reg;
    logic [3:0] err_next;
    logic [`INT_W-1:0] raw_reg;
    logic [`INT_W-1:0] raw_next;
    logic [`INT_W-1:0] ien_reg;
    logic [LW-1:0] level_prev_reg;
    logic idle_prev_reg;
    logic [3:0] modem_prev_reg;
    logic [3:0] modem_s;
    logic [31:0] rd_reg;
    logic [31:0] rd_next;
    logic irq_reg;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire logic hit_ctrl = (addr == `OFS_CTRL);
    wire logic hit_rxerr = (addr == `OFS_RXERR);
    wire logic hit_modem = (addr == `OFS_MODEM);
    wire logic hit_flags = (addr == `OFS_FLAGS);
    wire logic hit_raw = (addr == `OFS_RAW);
    wire logic hit_ien = (addr == `OFS_IEN);
    wire logic hit_iclr = (addr == `OFS_ICLR);
    wire logic hit_masked = (addr == `OFS_MASKED);

    wire logic wr_ctrl = wr_en && hit_ctrl;
    wire logic wr_ien = wr_en && hit_ien;
    wire logic wr_iclr = wr_en && hit_iclr;
    // any write here clears all four
    wire logic err_clear = wr_en && hit_rxerr;

    // control write fields
    wire logic [2:0] par_field = wr_data[`CTRL_PAR_MSB:`CTRL_PAR_LSB];
    // undefined codes leave the setting alone
    wire logic par_legal = (par_field <= `PAR_ZERO);
    wire logic [LW-1:0] thr_field = wr_data[`CTRL_THR_LSB +: LW];

    // ----------------------------------------
    // modem status inputs
    // ----------------------------------------
    // pins synchronised before use
    modem_sync #(
        .W(4)
    ) u_modem_sync (
        .mclk(mclk),
        .resetn(resetn),
        .pins({clear_to_send_in, data_set_ready_in,
               carrier_detect_in, ring_indicator_in}),
        .synced(modem_s)
    );

    wire logic [3:0] modem_chg = modem_s ^ modem_prev_reg;

    // ----------------------------------------
    // parity generation and check
    // ----------------------------------------
    parity_unit #(
        .DW(DW)
    ) u_parity (
        .mclk(mclk),
        .resetn(resetn),
        .mode(par_reg),
        .tx_data(tx_data),
        .rx_valid(rx_char.valid),
        .rx_data(rx_char.data),
        .rx_par_bit(rx_char.par_bit),
        .tx_par_bit(tx_par_bit),
        .rx_par_err(rx_par_err)
    );

    // ----------------------------------------
    // transmit status and events
    // ----------------------------------------
    // space while the fifo is not full
    wire logic tx_space = !tx_fifo_full;
    wire logic tx_idle = (tx_fifo_level == '0) && !tx_shift_busy;
    wire logic tx_lvl_evt = (level_prev_reg > thr_reg) &&
        (tx_fifo_level <= thr_reg);
    // fifo empty and last stop bit gone
    wire logic tx_idle_evt = tx_idle && !idle_prev_reg;
    wire logic tx_evt = (txmode_reg == tx_irq_on_idle) ?
        tx_idle_evt : tx_lvl_evt;

    // ----------------------------------------
    // receive error flags
    // ----------------------------------------
    // first occurrence of each error raises its interrupt
    wire logic fe_evt = rx_pop.valid && rx_pop.frame && !err_reg[`ERR_FE];
    wire logic pe_evt = rx_pop.valid && rx_pop.parity && !err_reg[`ERR_PE];
    wire logic be_evt = rx_pop.valid && rx_pop.brk && !err_reg[`ERR_BE];
    wire logic oe_evt = rx_overrun && !err_reg[`ERR_OE];

    // frame, parity and break flags load from popped character, else clear on a write to the error register, else hold
    always_comb begin
        err_next = err_reg;
        if (rx_pop.valid) begin
            err_next[`ERR_FE] = rx_pop.frame;
            err_next[`ERR_PE] = rx_pop.parity;
            err_next[`ERR_BE] = rx_pop.brk;
        end else if (err_clear) begin
            err_next[`ERR_FE] = 1'b0;
            err_next[`ERR_PE] = 1'b0;
            err_next[`ERR_BE] = 1'b0;
        end
        // overrun sets at once, set beats clear
        if (rx_overrun) begin
            err_next[`ERR_OE] = 1'b1;
        end else if (err_clear) begin
            err_next[`ERR_OE] = 1'b0;
        end
    end

    // ----------------------------------------
    // interrupt status
    // ----------------------------------------
    wire logic [`INT_W-1:0] int_set = {modem_chg, fe_evt, pe_evt,
                                       be_evt, oe_evt, tx_evt};
    wire logic [`INT_W-1:0] int_clr = wr_iclr ? wr_data[`INT_W-1:0] : '0;
    // new events win over a clear in the same cycle
    assign raw_next = (raw_reg & ~int_clr) | int_set;
    // only enabled sources reach the line
    wire logic [`INT_W-1:0] masked = raw_reg & ien_reg;

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // raw and masked views on two offsets
    always_comb begin
        rd_next = 32'h0000_0000;
        if (!rd_en) begin
            rd_next = 32'h0000_0000;
        end else if (hit_ctrl) begin
            rd_next[`CTRL_PAR_MSB:`CTRL_PAR_LSB] = par_reg;
            rd_next[`CTRL_SMART_BIT] = smart_reg;
            rd_next[`CTRL_TXMODE_BIT] = txmode_reg;
            rd_next[`CTRL_THR_LSB +: LW] = thr_reg;
        end else if (hit_rxerr) begin
            rd_next[3:0] = err_reg;
        end else if (hit_modem) begin
            rd_next[3:0] = modem_s;
        end else if (hit_flags) begin
            rd_next[`FLG_SPACE] = tx_space;
            rd_next[`FLG_IDLE] = tx_idle;
        end else if (hit_raw) begin
            rd_next[`INT_W-1:0] = raw_reg;
        end else if (hit_ien) begin
            rd_next[`INT_W-1:0] = ien_reg;
        end else if (hit_masked) begin
            rd_next[`INT_W-1:0] = masked;
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    // software writable settings
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            par_reg <= parity_off;
            smart_reg <= 1'b0;
            txmode_reg <= tx_irq_on_level;
            thr_reg <= `CTRL_THR_RESET;
        end else if (wr_ctrl) begin
            if (par_legal) begin
                par_reg <= parity_sel_t'(par_field);
            end
            smart_reg <= wr_data[`CTRL_SMART_BIT];
            txmode_reg <= tx_irq_mode_t'(wr_data[`CTRL_TXMODE_BIT]);
            thr_reg <= thr_field;
        end
    end

    // ----------------------------------------
    // status and history registers
    // ----------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            err_reg <= 4'h0;
            raw_reg <= '0;
            level_prev_reg <= '0;
            idle_prev_reg <= 1'b1;
            modem_prev_reg <= 4'h0;
        end else begin
            err_reg <= err_next;
            raw_reg <= raw_next;
            level_prev_reg <= tx_fifo_level;
            idle_prev_reg <= tx_idle;
            modem_prev_reg <= modem_s;
        end
    end

    // interrupt enables
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ien_reg <= '0;
        end else if (wr_ien) begin
            ien_reg <= wr_data[`INT_W-1:0];
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    // line high while an enabled bit is set
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rd_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
        end else begin
            rd_reg <= rd_next;
            irq_reg <= |masked;
        end
    end

    assign rd_data = rd_reg;
    assign irq = irq_reg;
    assign parity_mode = par_reg;
    assign smart_card_en = smart_reg;

endmodule : uart_ctl

// file: uart_ctl_map.svh
// Notes on behaviour
// - five parity settings shared by tx and rx
// - forced settings send constant parity bit
// - parity setting reads back as legal code
// - four receive error flags, separately readable
// - frame/parity/break follow last read character
// - overrun flag sets when overrun happens
// - one clear resets all four flags
// - live ring, carrier, dsr, cts states
// - smart card enable bit, set and clear
// - transmit fifo space flag
// - default tx interrupt on level threshold
// - idle mode interrupts on empty shifter
// - tx interrupt mode readable and writable
// - per-source enables gate the interrupt line
// - raw and masked status both readable
`ifndef UART_CTL_MAP_SVH
`define UART_CTL_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_RXERR 8'h04
`define OFS_MODEM 8'h08
`define OFS_FLAGS 8'h0c
`define OFS_RAW 8'h10
`define OFS_IEN 8'h14
`define OFS_ICLR 8'h18
`define OFS_MASKED 8'h1c

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CTRL_PAR_LSB 0
`define CTRL_PAR_MSB 2
`define CTRL_SMART_BIT 3
`define CTRL_TXMODE_BIT 4
`define CTRL_THR_LSB 8
`define CTRL_THR_W 5
`define CTRL_THR_RESET 5'h08
`define ERR_FE 0
`define ERR_PE 1
`define ERR_BE 2
`define ERR_OE 3
`define FLG_SPACE 0
`define FLG_IDLE 1
`define INT_TX 0
`define INT_OE 1
`define INT_BE 2
`define INT_PE 3
`define INT_FE 4
`define INT_MODEM_LSB 5
`define INT_W 9
`define PAR_NONE 3'h0
`define PAR_EVEN 3'h1
`define PAR_ODD 3'h2
`define PAR_ONE 3'h3
`define PAR_ZERO 3'h4

`endif

// file: uart_ctl_pkg.sv
package uart_ctl_pkg;
`include "uart_ctl_map.svh"

    // parity settings as seen on the control register
    typedef enum logic [2:0] {
        parity_off = `PAR_NONE,
        parity_even_sel = `PAR_EVEN,
        parity_odd_sel = `PAR_ODD,
        parity_forced_high = `PAR_ONE,
        parity_forced_low = `PAR_ZERO
    } parity_sel_t;

    typedef enum logic {
        tx_irq_on_level = 1'b0,
        tx_irq_on_idle = 1'b1
    } tx_irq_mode_t;

    // character arriving from the deserialiser
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic par_bit;
    } rx_char_t;

    // error bits of the character popped from the receive fifo
    typedef struct packed {
        logic valid;
        logic frame;
        logic parity;
        logic brk;
    } rx_pop_t;

endpackage : uart_ctl_pkg

// file: modem_sync.sv
`timescale 1ns/1ps
module modem_sync #(
    parameter int W = 4
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [W-1:0] pins,
    output logic [W-1:0] synced
);
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;

    // two flops, the first read only by the second
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= pins;
            stage2_reg <= stage1_reg;
        end
    end

    assign synced = stage2_reg;
endmodule : modem_sync

// file: parity_unit.sv
`timescale 1ns/1ps
module parity_unit
    import uart_ctl_pkg::*;
#(
    parameter int DW = 8
) (
    input wire logic mclk,
    input wire logic resetn,
    input parity_sel_t mode,
    input wire logic [DW-1:0] tx_data,
    input wire logic rx_valid,
    input wire logic [DW-1:0] rx_data,
    input wire logic rx_par_bit,
    output logic tx_par_bit,
    output logic rx_par_err
);
    logic tx_par_reg;
    logic rx_err_reg;

    // parity bit owed for a word under a setting
    function automatic logic par_of(parity_sel_t m, logic [DW-1:0] d);
        case (m)
            parity_even_sel: par_of = ^d;
            parity_odd_sel: par_of = ~^d;
            parity_forced_high: par_of = 1'b1;
            default: par_of = 1'b0;
        endcase
    endfunction : par_of

    wire logic tx_par_next = par_of(mode, tx_data);
    wire logic rx_err_next = rx_valid && (mode != parity_off) &&
        (rx_par_bit != par_of(mode, rx_data));

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_par_reg <= 1'b0;
            rx_err_reg <= 1'b0;
        end else begin
            tx_par_reg <= tx_par_next;
            rx_err_reg <= rx_err_next;
        end
    end

    assign tx_par_bit = tx_par_reg;
    assign rx_par_err = rx_err_reg;
endmodule : parity_unit

// file: uart_ctl_props.sv
`timescale 1ns/1ps
`include "uart_ctl_map.svh"
module uart_ctl_props
    import uart_ctl_pkg::*;
#(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [AW-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rd_data,
    input wire logic irq,
    input wire logic [DW-1:0] tx_data,
    input wire logic tx_par_bit,
    input rx_char_t rx_char,
    input wire logic rx_par_err,
    input parity_sel_t parity_mode,
    input wire logic smart_card_en
);
    // ----------------------------------------
    // port relations
    // ----------------------------------------
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!resetn);

    AST_RD_QUIET: assert property (!rd_en |=> rd_data == 32'h0)
        else $error("read data not zero outside a read");
    AST_PAR_HIGH: assert property (
        parity_mode == parity_forced_high |=> tx_par_bit)
        else $error("forced high parity not sent");
    AST_PAR_LOW: assert property (
        parity_mode == parity_forced_low |=> !tx_par_bit)
        else $error("forced low parity not sent");
    AST_PAR_EVEN: assert property (
        parity_mode == parity_even_sel |=> tx_par_bit == ^$past(tx_data))
        else $error("even parity bit wrong");
    AST_PAR_LEGAL: assert property ($changed(parity_mode) |->
        $past(wr_en) && $past(addr) == `OFS_CTRL && parity_mode <= 3'h4)
        else $error("parity setting changed without a legal write");
    AST_RX_ODD: assert property (
        rx_char.valid && parity_mode == parity_odd_sel |=>
        rx_par_err == (^$past(rx_char.data) == $past(rx_char.par_bit)))
        else $error("odd parity check wrong");
    AST_RX_NONE: assert property (
        !rx_char.valid || parity_mode == parity_off |=> !rx_par_err)
        else $error("parity error without a checked character");
    AST_SMART: assert property (
        wr_en && addr == `OFS_CTRL |=> smart_card_en == $past(wr_data[3]))
        else $error("smart card bit not written");
    AST_IRQ_MASK: assert property (
        rd_en && addr == `OFS_MASKED |=> irq == (rd_data != 32'h0))
        else $error("interrupt line disagrees with masked status");
endmodule : uart_ctl_props

bind uart_ctl uart_ctl_props #(.AW(AW), .DW(DW)) props_i (.mclk, .resetn,
    .addr, .wr_data, .wr_en, .rd_en, .rd_data, .irq, .tx_data, .tx_par_bit,
    .rx_char, .rx_par_err, .parity_mode, .smart_card_en);

// file: far_end.sv
`timescale 1ns/1ps
module far_end
    import uart_ctl_pkg::*;
(
    input wire logic mclk,
    output rx_char_t rx_char,
    output logic [3:0] pins
);
    // ----------------------------------------
    // remote serial device
    // ----------------------------------------
    // quiet line at start
    initial begin
        rx_char = '0;
        pins = 4'h0;
    end

    // parity bit per setting, optionally corrupted
    task automatic send(input parity_sel_t m, input logic [7:0] d,
                        input logic bad);
        logic p;
        p = (m == parity_forced_high) | (m == parity_even_sel & ^d) |
            (m == parity_odd_sel & ~^d);
        @(posedge mclk);
        rx_char <= '{1'b1, d, p ^ bad};
        @(posedge mclk);
        rx_char <= '{1'b0, ~d, ~p};  // no stale character after release
    endtask : send

    task automatic set_pins(input logic [3:0] v);
        @(posedge mclk);
        pins <= v;
    endtask : set_pins
endmodule : far_end

// file: uart_parity_error_txirq_modem_status_tb.sv
`timescale 1ns/1ps
`include "uart_ctl_map.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module uart_parity_error_txirq_modem_status_tb
    import uart_ctl_pkg::*;
;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] tx_data = 8'h00;
    rx_pop_t rx_pop = '0;
    logic rx_overrun = 1'b0;
    logic tx_fifo_full = 1'b0;
    logic tx_shift_busy = 1'b0;
    logic [4:0] tx_fifo_level = 5'h00;
    logic [31:0] rd_data, d;
    logic irq, tx_par_bit, rx_par_err, smart_card_en;
    rx_char_t rx_char;
    parity_sel_t parity_mode;
    logic [3:0] pins, e;
    int n_errors = 0;
    int checks = 0;

    // ----------------------------------------
    // clock, partner, design
    // ----------------------------------------
    initial forever #25 mclk = ~mclk;
    far_end far (.mclk(mclk), .rx_char(rx_char), .pins(pins));
    uart_ctl dut (.mclk, .resetn, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
        .irq, .tx_data, .tx_par_bit, .rx_char, .rx_par_err, .rx_pop,
        .rx_overrun, .tx_fifo_level, .tx_fifo_full, .tx_shift_busy,
        .ring_indicator_in(pins[0]), .carrier_detect_in(pins[1]),
        .data_set_ready_in(pins[2]), .clear_to_send_in(pins[3]),
        .parity_mode, .smart_card_en);

    // ----------------------------------------
    // bus cycles and expectations
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= v;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        // data stand only in the cycle after the strobe
        #1 v = rd_data;
    endtask : rd

    task automatic pulse_ovr;
        @(posedge mclk);
        rx_overrun <= 1'b1;
        @(posedge mclk);
        rx_overrun <= 1'b0;
        @(posedge mclk);
    endtask : pulse_ovr

    function automatic logic exp_par(parity_sel_t m, logic [7:0] v);
        return (m == parity_forced_high) | (m == parity_even_sel & ^v) |
            (m == parity_odd_sel & ~^v);
    endfunction : exp_par

    task automatic tally_and_finish;
        if (n_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        parity_sel_t m;
        logic [7:0] v;
        logic b;
        logic [3:0] chg;
        logic [3:0] prv;
        void'($urandom(13799));
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        rd(`OFS_CTRL, d);
        `CHK(d, 32'h0000_0800)
        rd(8'h20, d);
        `CHK(d, 32'h0)
        // every parity setting with random characters both ways
        for (int i = 0; i < 5; i++) begin
            m = parity_sel_t'(i);
            wr(`OFS_CTRL, 32'h0000_0800 | 32'(i));
            rd(`OFS_CTRL, d);
            `CHK(d[2:0], m)
            `CHK(parity_mode, m)
            repeat (4) begin
                v = 8'($urandom);
                b = 1'($urandom);
                @(posedge mclk);
                tx_data <= v;
                @(posedge mclk);
                #1 `CHK(tx_par_bit, exp_par(m, v))
                far.send(m, v, b);
                #1 `CHK(rx_par_err, b & (m != parity_off))
            end
        end
        wr(`OFS_CTRL, 32'h0000_0805);
        rd(`OFS_CTRL, d);
        `CHK(d, 32'h0000_0804)
        `CHK(parity_mode, parity_forced_low)
        // smart card on with even parity, then off
        wr(`OFS_CTRL, 32'h0000_0809);
        #1 `CHK(smart_card_en, 1'b1)
        wr(`OFS_CTRL, 32'h0000_0801);
        rd(`OFS_CTRL, d);
        `CHK(d, 32'h0000_0801)
        // error flags follow each popped character
        for (int i = 0; i < 4; i++) begin
            e = 4'($urandom) & 4'h7;
            @(posedge mclk);
            rx_pop <= '{1'b1, e[0], e[1], e[2]};
            @(posedge mclk);
            rx_pop <= '0;
            rd(`OFS_RXERR, d);
            `CHK(d[3:0], e)
        end
        // overrun at once, interrupt, then clear in order
        wr(`OFS_IEN, 32'h0000_0003);
        pulse_ovr();
        #1 `CHK(irq, 1'b1)
        rd(`OFS_MASKED, d);
        `CHK(d[8:0], 9'h002)
        rd(`OFS_RXERR, d);
        `CHK(d[3], 1'b1)
        wr(`OFS_ICLR, 32'h0000_0002);
        wr(`OFS_RXERR, 32'h0);
        rd(`OFS_RXERR, d);
        `CHK(d[3:0], 4'h0)
        `CHK(irq, 1'b0)
        // disabled source stays off the line
        wr(`OFS_IEN, 32'h0000_0001);
        pulse_ovr();
        rd(`OFS_RAW, d);
        `CHK(d[1], 1'b1)
        `CHK(irq, 1'b0)
        // level crossing of the threshold
        @(posedge mclk);
        tx_fifo_level <= 5'h09;
        @(posedge mclk);
        tx_fifo_level <= 5'h08;
        repeat (2) @(posedge mclk);
        #1 `CHK(irq, 1'b1)
        wr(`OFS_ICLR, 32'h0000_0001);
        // end of transmission waits for the shifter
        @(posedge mclk);
        tx_fifo_level <= 5'h00;
        tx_shift_busy <= 1'b1;
        wr(`OFS_CTRL, 32'h0000_0811);
        repeat (3) @(posedge mclk);
        #1 `CHK(irq, 1'b0)
        @(posedge mclk);
        tx_shift_busy <= 1'b0;
        repeat (3) @(posedge mclk);
        #1 `CHK(irq, 1'b1)
        rd(`OFS_CTRL, d);
        `CHK(d[4], 1'b1)
        rd(`OFS_FLAGS, d);
        `CHK(d[1], 1'b1)
        // modem lines and transmit space
        chg = 4'h0;
        prv = 4'h0;
        repeat (3) begin
            v = 8'($urandom);
            far.set_pins(v[3:0]);
            chg = chg | (v[3:0] ^ prv);
            prv = v[3:0];
            tx_fifo_full <= v[4];
            repeat (3) @(posedge mclk);
            rd(`OFS_MODEM, d);
            `CHK(d[3:0], v[3:0])
            rd(`OFS_FLAGS, d);
            `CHK(d[0], ~v[4])
        end
        // every line that moved left its sticky change bit
        rd(`OFS_RAW, d);
        `CHK(d[8:5], chg)
        tally_and_finish();
    end
endmodule : uart_parity_error_txirq_modem_status_tb
